// File: src/wss_pkg.sv
package wss_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] WSS_IDX_CTRL       = 8'h0c;
    localparam logic [7:0] WSS_IDX_SLOT_FIRST = 8'h0f;
    localparam logic [7:0] WSS_IDX_SLOT_SECOND = 8'h10;
    localparam logic [7:0] WSS_IDX_SLOT_FIVE  = 8'h13;
    localparam logic [7:0] WSS_IDX_SLOT_SIX   = 8'h14;
    localparam logic [7:0] WSS_IDX_SLOT_LAST  = 8'h16;
    localparam logic [7:0] WSS_IDX_STATUS     = 8'h20;

    // Number of sequence slots and the value of the last slot pointer.
    localparam int         WSS_NUM_SLOTS = 8;
    localparam logic [2:0] WSS_PTR_LAST  = 3'h7;

    // Slot layout: delay flag on top, seven-bit field below.
    localparam int         WSS_SLOT_FLAG_BIT = 7;
    localparam int         WSS_FIELD_W       = 7;
    localparam logic [7:0] WSS_SLOT_RESET    = 8'h00;

    // Control and status fields.
    localparam int WSS_CTRL_TRIGGER_BIT = 0;
    localparam int WSS_STAT_BUSY_BIT    = 0;
    localparam int WSS_STAT_PTR_LSB     = 4;

    // Delay tick: ten milliseconds at the system clock rate.
    localparam int WSS_TICK_MS       = 10;
    localparam int WSS_CLK_KHZ       = 125000;
    localparam int WSS_TICK_CYCLES   = WSS_TICK_MS * WSS_CLK_KHZ;

    // AHB-Lite encodings.
    localparam logic [1:0] WSS_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] WSS_HTRANS_SEQ    = 2'h3;
    localparam logic       WSS_HRESP_OKAY    = 1'h0;

    // Sequencer states.
    typedef enum logic [1:0] {
        WSS_ST_IDLE  = 2'b00,
        WSS_ST_FETCH = 2'b01,
        WSS_ST_PLAY  = 2'b10,
        WSS_ST_WAIT  = 2'b11
    } wss_state_t;

endpackage

// File: src/wss_sequencer.sv
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps

// Function
// RULE1 - Delay flag set makes the slot an idle period with no playback.
// RULE2 - Idle period lasts ten milliseconds times the slot's seven-bit field.
// RULE3 - Delay flag clear makes the seven-bit field a waveform identifier.
// RULE4 - Identifier bits six to zero index a waveform in the library.
// RULE5 - Software sets the trigger bit; playback begins at the first slot.
// RULE6 - After a waveform ends, advance to the next slot and continue.
// RULE7 - Stop after all eight slots have been used.
// RULE8 - A zero slot entry stops playback instead of playing.
// RULE9 - Slots five and six are read-write, eight bits, reset to zero.
// RULE10 - Delay is counted in ten-millisecond ticks from the device clock.
module wss_sequencer
    import wss_pkg::*;
#(
    parameter int ADDR_W      = 32,
    parameter int TICK_CYCLES = WSS_TICK_CYCLES
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata_q,
    output logic                   hreadyout_q,
    output logic                   hresp_q,
    input  wire logic              wave_done,
    output logic                   wave_play_q,
    output logic      [6:0]        wave_index_q,
    output logic                   seq_busy_q,
    output logic                   seq_idle_q
);

    initial begin
        if (ADDR_W < 10) begin
            $error("ADDR_W must be at least ten");
        end
    end

    logic [7:0]        slot_q [WSS_NUM_SLOTS];
    logic              trigger_q;
    wss_state_t        state_q;
    logic [2:0]        ptr_q;
    logic [6:0]        delay_q;
    logic              wr_pend_q;
    logic [7:0]        wr_idx_q;
    logic              tick;
    logic              tick_clear;
    logic              addr_valid;
    logic [7:0]        addr_idx;
    logic [7:0]        cur_entry;
    logic              seq_start;
    logic              seq_stop;

    // Register index of a byte address.
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        return a[9:2];
    endfunction

    // True when an index falls on one of the sequence slots.
    function automatic logic is_slot(input logic [7:0] idx);
        return (idx >= WSS_IDX_SLOT_FIRST) && (idx <= WSS_IDX_SLOT_LAST);
    endfunction

    // Slot number of a slot index.
    function automatic logic [2:0] slot_num(input logic [7:0] idx);
        logic [7:0] diff;
        diff = idx - WSS_IDX_SLOT_FIRST;
        return diff[2:0];
    endfunction

    // Read value of a register index, zero where nothing is mapped.
    function automatic logic [31:0] read_value(input logic [7:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (idx == WSS_IDX_CTRL) begin
            v[WSS_CTRL_TRIGGER_BIT] = trigger_q;
        end else if (is_slot(idx)) begin
            v[7:0] = slot_q[slot_num(idx)];
        end else if (idx == WSS_IDX_STATUS) begin
            v[WSS_STAT_BUSY_BIT] = (state_q != WSS_ST_IDLE);
            v[WSS_STAT_PTR_LSB +: 3] = ptr_q;
        end
        return v;
    endfunction

    assign addr_valid = hsel && hready && (htrans == WSS_HTRANS_NONSEQ || htrans == WSS_HTRANS_SEQ);
    assign addr_idx   = reg_index(haddr);
    assign cur_entry  = slot_q[ptr_q];

    // Accepted width is a whole word; narrower accesses still land in the low byte.
    wire unused_size = ^hsize;

    // Every transfer completes with no wait state and an OKAY response.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q     <= WSS_HRESP_OKAY;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= WSS_HRESP_OKAY;
        end
    end

    // Address phase of a write is held for its data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end else begin
            wr_pend_q <= addr_valid && hwrite;
            if (addr_valid && hwrite) begin
                wr_idx_q <= addr_idx;
            end
        end
    end

    // Read data is prepared in the address phase, bypassing a write still in its data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_valid && !hwrite) begin
            if (wr_pend_q && wr_idx_q == addr_idx && (is_slot(addr_idx) || addr_idx == WSS_IDX_CTRL)) begin
                hrdata_q <= (addr_idx == WSS_IDX_CTRL) ? {31'h0, hwdata[WSS_CTRL_TRIGGER_BIT]}
                                                        : {24'h0, hwdata[7:0]};
            end else begin
                hrdata_q <= read_value(addr_idx);
            end
        end
    end

    // Slot storage, all eight reading and writing the full byte.
    // RULE9 slot register storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < WSS_NUM_SLOTS; i++) begin
                slot_q[i] <= WSS_SLOT_RESET;
            end
        end else if (wr_pend_q && is_slot(wr_idx_q)) begin
            slot_q[slot_num(wr_idx_q)] <= hwdata[7:0];
        end
    end

    // A trigger written while idle starts a sequence; writing zero aborts one.
    // RULE5 trigger starts playback
    assign seq_start = wr_pend_q && (wr_idx_q == WSS_IDX_CTRL) && hwdata[WSS_CTRL_TRIGGER_BIT]
                       && (state_q == WSS_ST_IDLE);

    // Trigger bit: software sets it, the sequencer drops it when the sequence ends.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trigger_q <= 1'b0;
        end else if (wr_pend_q && wr_idx_q == WSS_IDX_CTRL) begin
            trigger_q <= hwdata[WSS_CTRL_TRIGGER_BIT];
        end else if (seq_stop) begin
            trigger_q <= 1'b0;
        end
    end

    // Ten-millisecond tick, restarted whenever a delay is loaded.
    // RULE10 tick divider
    assign tick_clear = (state_q != WSS_ST_WAIT);

    wss_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clear   (tick_clear),
        .tick_q  (tick)
    );

    // Sequence ends on a zero entry, after the last slot, or on an abort write.
    // RULE7 stop after eighth
    // RULE8 zero entry stops
    assign seq_stop = (state_q == WSS_ST_FETCH && cur_entry == 8'h00)
                      || (state_q == WSS_ST_PLAY && wave_done && ptr_q == WSS_PTR_LAST)
                      || (state_q == WSS_ST_WAIT && (delay_q == 7'h00 || (tick && delay_q == 7'h01))
                          && ptr_q == WSS_PTR_LAST)
                      || (state_q != WSS_ST_IDLE && wr_pend_q && wr_idx_q == WSS_IDX_CTRL
                          && !hwdata[WSS_CTRL_TRIGGER_BIT]);

    // Slot walking state machine.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= WSS_ST_IDLE;
            ptr_q   <= 3'h0;
            delay_q <= 7'h00;
        end else if (seq_stop) begin
            state_q <= WSS_ST_IDLE;
        end else begin
            case (state_q)
                WSS_ST_IDLE: begin
                    // RULE5 begin at first slot
                    if (seq_start) begin
                        ptr_q   <= 3'h0;
                        state_q <= WSS_ST_FETCH;
                    end
                end
                WSS_ST_FETCH: begin
                    // RULE1 delay flag idles
                    if (cur_entry[WSS_SLOT_FLAG_BIT]) begin
                        // RULE2 load delay length
                        delay_q <= cur_entry[WSS_FIELD_W-1:0];
                        state_q <= WSS_ST_WAIT;
                    end else begin
                        // RULE3 identifier is played
                        state_q <= WSS_ST_PLAY;
                    end
                end
                WSS_ST_PLAY: begin
                    // RULE6 advance after waveform
                    if (wave_done) begin
                        ptr_q   <= ptr_q + 3'h1;
                        state_q <= WSS_ST_FETCH;
                    end
                end
                WSS_ST_WAIT: begin
                    // RULE10 advance on expiry
                    if (delay_q == 7'h00 || (tick && delay_q == 7'h01)) begin
                        // The last slot's expiry is caught by the stop term instead.
                        ptr_q   <= ptr_q + 3'h1;
                        state_q <= WSS_ST_FETCH;
                    end else if (tick) begin
                        delay_q <= delay_q - 7'h01;
                    end
                end
                default: begin
                    state_q <= WSS_ST_IDLE;
                end
            endcase
        end
    end

    // Play request to the drive logic, one pulse per waveform slot.
    // RULE4 identifier indexes library
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wave_play_q  <= 1'b0;
            wave_index_q <= 7'h00;
        end else if (state_q == WSS_ST_FETCH && !seq_stop && !cur_entry[WSS_SLOT_FLAG_BIT]) begin
            wave_play_q  <= 1'b1;
            wave_index_q <= cur_entry[WSS_FIELD_W-1:0];
        end else begin
            wave_play_q  <= 1'b0;
        end
    end

    // Status outputs: busy through the sequence, idle while a delay slot runs.
    // RULE1 engine idles in delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_busy_q <= 1'b0;
            seq_idle_q <= 1'b0;
        end else begin
            seq_busy_q <= (state_q != WSS_ST_IDLE || seq_start) && !seq_stop;
            seq_idle_q <= (state_q == WSS_ST_FETCH && cur_entry[WSS_SLOT_FLAG_BIT] && !seq_stop)
                          || (state_q == WSS_ST_WAIT && !seq_stop && !(delay_q == 7'h00
                              || (tick && delay_q == 7'h01)));
        end
    end

endmodule

// File: src/wss_tick_gen.sv
`timescale 1ns/10ps

// Produces a one-cycle enable every TICK_CYCLES clocks, restarted by clear.
module wss_tick_gen #(
    parameter int TICK_CYCLES = 1250000
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic clear,
    output logic      tick_q
);

    localparam int CNT_W = $clog2(TICK_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CYCLES - 1);

    logic [CNT_W-1:0] cnt_q;

    initial begin
        if (TICK_CYCLES < 1) begin
            $error("TICK_CYCLES must be at least one");
        end
    end

    // Free-running divider that a restart brings back to zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (clear) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q == CNT_LAST) begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

endmodule

// File: verif/test_waveform_sequence_slots.sv
`timescale 1ns/10ps

// Drives the sequencer registers over the bus and answers for the drive logic.
module test_waveform_sequence_slots
    import wss_pkg::*;
;
    localparam int TICK = 10;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hready, wave_done;
    logic        hreadyout_q, hresp_q, wave_play_q, seq_busy_q, seq_idle_q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [6:0]  wave_index_q;
    logic [31:0] haddr, hwdata, hrdata_q, rd;
    logic [6:0]  plays[$];
    int          n_fail, check_count, idle_n;

    // Clock at 125 MHz; the slave's ready is the bus ready.
    always #4 hclk = ~hclk;
    assign hready = hreadyout_q;

    wss_sequencer #(.ADDR_W(32), .TICK_CYCLES(TICK)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q),
        .hresp_q(hresp_q), .wave_done(wave_done), .wave_play_q(wave_play_q), .wave_index_q(wave_index_q),
        .seq_busy_q(seq_busy_q), .seq_idle_q(seq_idle_q));

    // Compares one value and counts the outcome.
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One single word transfer; read data lands in rd at the data-phase edge.
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        int n;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= WSS_HTRANS_NONSEQ;
        hwrite <= wr;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hready !== 1'b1 && n < 64);
            if (n >= 64) begin
                n_fail++;
                end_of_test();
            end
            if (p == 0) begin
                htrans <= 2'h0;
                hwdata <= wd;
            end
        end
        rd = hrdata_q;
    endtask

    // Triggers playback and answers every play pulse with a finished pulse.
    task automatic run_seq;
        int n;
        plays.delete();
        idle_n = 0;
        xfer(WSS_IDX_CTRL, 1'b1, 32'h1);
        for (n = 0; n < 3000; n++) begin
            @(posedge hclk);
            wave_done <= (wave_play_q === 1'b1);
            if (wave_play_q === 1'b1) begin
                plays.push_back(wave_index_q);
            end
            if (seq_idle_q === 1'b1) begin
                idle_n++;
            end
            if (n > 4 && seq_busy_q === 1'b0) begin
                break;
            end
        end
        if (n >= 3000) begin
            n_fail++;
            end_of_test();
        end
    endtask

    // Main sequence of tests.
    initial begin
        {hresetn, hwrite, wave_done, htrans, haddr, hwdata} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        n_fail = 0;
        check_count = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(WSS_IDX_SLOT_FIVE, 1'b0, 32'h0);
        check("slot_five_reset", 32'h0, rd);
        xfer(WSS_IDX_SLOT_SIX, 1'b0, 32'h0);
        check("slot_six_reset", 32'h0, rd);
        xfer(WSS_IDX_SLOT_FIVE, 1'b1, 32'hffff_ffff);
        xfer(WSS_IDX_SLOT_SIX, 1'b1, 32'h0000_005a);
        xfer(WSS_IDX_SLOT_FIVE, 1'b0, 32'h0);
        check("slot_five_entry", 32'h0000_00ff, rd);
        xfer(WSS_IDX_SLOT_SIX, 1'b0, 32'h0);
        check("slot_six_entry", 32'h0000_005a, rd);
        xfer(8'h3f, 1'b0, 32'h0);
        check("unmapped_read", 32'h0, rd);
        $display("test registers done");
        xfer(WSS_IDX_SLOT_FIRST, 1'b1, 32'h05);
        xfer(WSS_IDX_SLOT_SECOND, 1'b1, 32'h83);
        xfer(8'h11, 1'b1, 32'h22);
        xfer(8'h12, 1'b1, 32'h00);
        run_seq();
        check("play_count", 32'h2, 32'(plays.size()));
        check("first_index", 32'h05, {25'h0, plays[0]});
        check("second_index", 32'h22, {25'h0, plays[1]});
        check("delay_in_range", 32'h1, 32'(idle_n >= 3 * TICK && idle_n <= 3 * TICK + 2));
        xfer(WSS_IDX_CTRL, 1'b0, 32'h0);
        check("trigger_cleared", 32'h0, rd);
        xfer(WSS_IDX_STATUS, 1'b0, 32'h0);
        check("status_after_stop", 32'h30, rd);
        $display("test delay sequence done");
        xfer(WSS_IDX_SLOT_FIRST, 1'b1, 32'hff);
        xfer(WSS_IDX_CTRL, 1'b1, 32'h1);
        xfer(WSS_IDX_STATUS, 1'b0, 32'h0);
        check("status_busy", 32'h1, rd);
        xfer(WSS_IDX_CTRL, 1'b1, 32'h0);
        xfer(WSS_IDX_CTRL, 1'b0, 32'h0);
        check("abort_trigger", 32'h0, rd);
        check("abort_busy", 32'h0, {31'h0, seq_busy_q});
        check("abort_idle", 32'h0, {31'h0, seq_idle_q});
        $display("test abort done");
        for (int i = 0; i < WSS_NUM_SLOTS; i++) begin
            xfer(8'(WSS_IDX_SLOT_FIRST + i), 1'b1, 32'(i + 1));
        end
        run_seq();
        check("full_count", 32'h8, 32'(plays.size()));
        check("last_index", 32'h08, {25'h0, plays[7]});
        xfer(WSS_IDX_SLOT_FIRST, 1'b1, 32'h0);
        run_seq();
        check("zero_first_count", 32'h0, 32'(plays.size()));
        $display("test full sequence done");
        end_of_test();
    end
endmodule

// File: verif/wss_sequencer_asserts.sv
`timescale 1ns/10ps

// Watches the bus response and the playback outputs of the sequencer.
module wss_sequencer_asserts
    import wss_pkg::*;
#(
    parameter int TICK_CYCLES = WSS_TICK_CYCLES
) (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hreadyout_q,
    input wire logic       hresp_q,
    input wire logic       wave_play_q,
    input wire logic [6:0] wave_index_q,
    input wire logic       seq_busy_q,
    input wire logic       seq_idle_q
);
    logic [31:0] idle_run_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Counts consecutive cycles spent in a delay slot.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_run_q <= 32'h0;
        end else begin
            idle_run_q <= seq_idle_q ? idle_run_q + 32'h1 : 32'h0;
        end
    end

    // A play request lasts exactly one cycle.
    sequence play_pulse_s;
        wave_play_q ##1 !wave_play_q;
    endsequence

    ready_high_a: assert property (hreadyout_q) else $error("bus wait state seen");
    resp_okay_a: assert property (hresp_q == WSS_HRESP_OKAY) else $error("bus error response");
    play_pulse_a: assert property ($rose(wave_play_q) |-> play_pulse_s) else $error("play pulse too long");
    idle_quiet_a: assert property (seq_idle_q |-> !wave_play_q) else $error("play during delay");
    play_busy_a: assert property (wave_play_q |-> seq_busy_q) else $error("play while not busy");
    index_hold_a: assert property (!wave_play_q |-> $stable(wave_index_q)) else $error("index moved");
    index_nonzero_a: assert property (wave_play_q |-> wave_index_q != 7'h0) else $error("zero entry played");
    idle_busy_a: assert property (seq_idle_q |-> seq_busy_q) else $error("delay outside sequence");
    idle_bound_a: assert property (idle_run_q <= 127 * TICK_CYCLES + 2) else $error("delay too long");
endmodule

bind wss_sequencer wss_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q), .wave_play_q(wave_play_q),
    .wave_index_q(wave_index_q), .seq_busy_q(seq_busy_q), .seq_idle_q(seq_idle_q));
